// ==== verilog/ricg_device.sv ====
// Function
// - hold family, 48-bit serial, check byte
// - check byte from x8+x5+x4+1 shift register
// - clear shift register before each code
// - shift family lsb first, then serial
// - receiver checks code returns register to zero
// - every byte moves least significant bit first
// - refuse memory commands before identity selection; 0x55 and 0xF0 decode as match and search instead
// - master issues one identity-selection command first
// - after selection, accept one memory command
`timescale 1ns/1ps
module ricg_device #(
  // identity values are arbitrary
  parameter logic [7:0]  FAMILY = 8'h5A,
  parameter logic [47:0] SERIAL = 48'h0123_4567_89AB
) (
  ricg_if.dev         bus,
  input  wire logic   clk,
  input  wire logic   rst,
  output logic        selected,
  output logic [7:0]  mem_cmd,
  output logic        mem_cmd_vld,
  output logic        mem_cmd_rej,
  output logic [7:0]  check_byte
);
  typedef enum logic [7:0] {
    ST_INIT   = 8'h01,
    ST_ROMCMD = 8'h02,
    ST_RDID   = 8'h04,
    ST_MATCH  = 8'h08,
    ST_SRCH   = 8'h10,
    ST_MEMCMD = 8'h20,
    ST_ACTIVE = 8'h40,
    ST_DESEL  = 8'h80
  } ricg_dst_t;

  ricg_dst_t        state_ff;
  ricg_dst_t        nxt_state;
  logic [6:0]       cnt_ff;
  logic [6:0]       nxt_cnt;
  logic [1:0]       phase_ff;
  logic [1:0]       nxt_phase;
  logic [7:0]       sh_ff;
  logic [7:0]       crc_ff;
  logic [7:0]       check_ff;
  logic [7:0]       mem_cmd_ff;
  logic             mem_vld_ff;
  logic             mem_rej_ff;
  logic             sel_ff;
  logic             d_vld_ff;
  logic             d_bit_ff;
  logic             rdy_ff;
  logic [ricg_pkg::ID_W-1:0]   rom_w;
  logic [ricg_pkg::BODY_W-1:0] body_w;
  logic [7:0]       byte_in;
  logic             rom_bit;
  logic             out_bit;
  logic             accept;
  logic             reject;

  assign body_w  = {SERIAL, FAMILY};
  assign rom_w   = {check_ff, body_w};
  assign rom_bit = rom_w[cnt_ff[5:0]];
  assign byte_in = {bus.m_bit, sh_ff[7:1]};

  // value the device leaves on the line in this slot; 1 means released
  always_comb begin
    case (state_ff)
      ST_RDID: out_bit = rom_bit;
      ST_SRCH: out_bit = (phase_ff == 2'h1) ? ~rom_bit : rom_bit;
      default: out_bit = 1'b1;
    endcase
  end

  // next-state decode, evaluated on every master slot
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_phase = phase_ff;
    accept    = 1'b0;
    reject    = 1'b0;
    case (state_ff)
      ST_INIT: begin
        nxt_cnt = cnt_ff + 7'h01;
        if (cnt_ff == ricg_pkg::BODY_LAST) begin
          nxt_state = ST_ROMCMD;
          nxt_cnt   = 7'h00;
        end
      end
      ST_ROMCMD: if (bus.m_vld) begin
        nxt_cnt = cnt_ff + 7'h01;
        if (cnt_ff == ricg_pkg::BYTE_LAST) begin
          nxt_cnt   = 7'h00;
          nxt_phase = 2'h0;
          case (byte_in)
            ricg_pkg::CMD_READ_ID:  nxt_state = ST_RDID;
            ricg_pkg::CMD_MATCH_ID: nxt_state = ST_MATCH;
            ricg_pkg::CMD_SRCH_ID:  nxt_state = ST_SRCH;
            ricg_pkg::CMD_SKIP_ID:  nxt_state = ST_MEMCMD;
            // any other byte here is refused, memory commands 0x0F and 0xAA included: no selection has run yet
            default:                nxt_state = ST_DESEL;
          endcase
        end
      end
      ST_RDID: if (bus.m_vld) begin
        nxt_cnt = cnt_ff + 7'h01;
        if (cnt_ff == ricg_pkg::ID_LAST) begin
          nxt_state = ST_MEMCMD;
          nxt_cnt   = 7'h00;
        end
      end
      ST_MATCH: if (bus.m_vld) begin
        nxt_cnt = cnt_ff + 7'h01;
        if (bus.m_bit != rom_bit) begin
          nxt_state = ST_DESEL;
        end else if (cnt_ff == ricg_pkg::ID_LAST) begin
          nxt_state = ST_MEMCMD;
          nxt_cnt   = 7'h00;
        end
      end
      ST_SRCH: if (bus.m_vld) begin
        nxt_phase = phase_ff + 2'h1;
        if (phase_ff == 2'h2) begin
          nxt_phase = 2'h0;
          nxt_cnt   = cnt_ff + 7'h01;
          if (bus.m_bit != rom_bit) begin
            nxt_state = ST_DESEL;
          end else if (cnt_ff == ricg_pkg::ID_LAST) begin
            nxt_state = ST_MEMCMD;
            nxt_cnt   = 7'h00;
          end
        end
      end
      ST_MEMCMD: if (bus.m_vld) begin
        nxt_cnt = cnt_ff + 7'h01;
        if (cnt_ff == ricg_pkg::BYTE_LAST) begin
          nxt_cnt = 7'h00;
          case (byte_in)
            ricg_pkg::MEM_WR_SP, ricg_pkg::MEM_RD_SP,
            ricg_pkg::MEM_CP_SP, ricg_pkg::MEM_RD_MEM: begin
              accept    = 1'b1;
              nxt_state = ST_ACTIVE;
            end
            default: begin
              reject    = 1'b1;
              nxt_state = ST_DESEL;
            end
          endcase
        end
      end
      default: nxt_state = state_ff;
    endcase
    // a bus reset throws away any selection, but never the init pass
    if (bus.bus_rst && state_ff != ST_INIT) begin
      nxt_state = ST_ROMCMD;
      nxt_cnt   = 7'h00;
      nxt_phase = 2'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_INIT;
      cnt_ff   <= 7'h00;
      phase_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      phase_ff <= nxt_phase;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_ff <= 8'h00;
    end else if (bus.m_vld) begin
      sh_ff <= byte_in;
    end
  end

  // check byte built once after reset, one body bit per cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_ff   <= ricg_pkg::CRC_INIT;
      check_ff <= 8'h00;
    end else if (state_ff == ST_INIT) begin
      crc_ff <= ricg_pkg::ricg_crc_step(crc_ff, body_w[cnt_ff[5:0]]);
      if (cnt_ff == ricg_pkg::BODY_LAST) begin
        check_ff <= ricg_pkg::ricg_crc_step(crc_ff, body_w[cnt_ff[5:0]]);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      d_vld_ff <= 1'b0;
      d_bit_ff <= 1'b1;
      rdy_ff   <= 1'b0;
    end else begin
      d_vld_ff <= bus.m_vld;
      // wired-and: the device can only pull a released slot low
      d_bit_ff <= bus.m_vld ? (bus.m_bit & out_bit) : 1'b1;
      rdy_ff   <= (state_ff != ST_INIT);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_cmd_ff <= 8'h00;
      mem_vld_ff <= 1'b0;
      mem_rej_ff <= 1'b0;
      sel_ff     <= 1'b0;
    end else begin
      mem_vld_ff <= accept;
      mem_rej_ff <= reject;
      if (accept) begin
        mem_cmd_ff <= byte_in;
      end
      sel_ff <= (nxt_state == ST_MEMCMD) || (nxt_state == ST_ACTIVE);
    end
  end

  assign bus.d_vld   = d_vld_ff;
  assign bus.d_bit   = d_bit_ff;
  assign bus.d_rdy   = rdy_ff;
  assign selected    = sel_ff;
  assign mem_cmd     = mem_cmd_ff;
  assign mem_cmd_vld = mem_vld_ff;
  assign mem_cmd_rej = mem_rej_ff;
  assign check_byte  = check_ff;
endmodule : ricg_device

// ==== verilog/ricg_pkg.sv ====
package ricg_pkg;
  // identity layout, transmitted least significant bit first
  localparam int          FAMILY_W     = 8;
  localparam int          SERIAL_W     = 48;
  localparam int          CHECK_W      = 8;
  localparam int          ID_W         = 64;
  localparam int          BODY_W       = FAMILY_W + SERIAL_W;
  localparam logic [6:0]  BODY_LAST    = 7'h37;
  localparam logic [6:0]  ID_LAST      = 7'h3F;
  localparam logic [6:0]  BYTE_LAST    = 7'h07;
  // x^8 + x^5 + x^4 + 1, reflected for lsb-first shifting
  localparam logic [7:0]  CRC_POLY_REF = 8'h8C;
  localparam logic [7:0]  CRC_INIT     = 8'h00;
  // identity-selection commands
  localparam logic [7:0]  CMD_READ_ID  = 8'h33;
  localparam logic [7:0]  CMD_MATCH_ID = 8'h55;
  localparam logic [7:0]  CMD_SRCH_ID  = 8'hF0;
  localparam logic [7:0]  CMD_SKIP_ID  = 8'hCC;
  // memory function commands
  localparam logic [7:0]  MEM_WR_SP    = 8'h0F;
  localparam logic [7:0]  MEM_RD_SP    = 8'hAA;
  localparam logic [7:0]  MEM_CP_SP    = 8'h55;
  localparam logic [7:0]  MEM_RD_MEM   = 8'hF0;
  // master selection operations
  localparam logic [1:0]  OP_READ      = 2'h0;
  localparam logic [1:0]  OP_MATCH     = 2'h1;
  localparam logic [1:0]  OP_SKIP      = 2'h2;

  // one step of the check-byte shift register
  function automatic logic [7:0] ricg_crc_step(input logic [7:0] crc, input logic din);
    logic fb;
    fb = crc[0] ^ din;
    ricg_crc_step = fb ? ((crc >> 1) ^ CRC_POLY_REF) : (crc >> 1);
  endfunction : ricg_crc_step
endpackage : ricg_pkg

// ==== verilog/ricg_if.sv ====
`timescale 1ns/1ps
interface ricg_if;
  logic bus_rst;
  logic m_vld;
  logic m_bit;
  logic d_vld;
  logic d_bit;
  logic d_rdy;

  modport dev (
    input  bus_rst,
    input  m_vld,
    input  m_bit,
    output d_vld,
    output d_bit,
    output d_rdy
  );
  modport mst (
    output bus_rst,
    output m_vld,
    output m_bit,
    input  d_vld,
    input  d_bit,
    input  d_rdy
  );
endinterface : ricg_if

// ==== verilog/ricg_master.sv ====
`timescale 1ns/1ps
module ricg_master (
  ricg_if.mst          bus,
  input  wire logic    clk,
  input  wire logic    rst,
  input  wire logic    start,
  input  wire logic [1:0]  op,
  input  wire logic [63:0] match_id,
  input  wire logic [7:0]  mem_cmd,
  output logic         busy,
  output logic         done,
  output logic [63:0]  id_read,
  output logic         crc_ok
);
  typedef enum logic [6:0] {
    M_IDLE = 7'h01,
    M_RST  = 7'h02,
    M_CMD  = 7'h04,
    M_RDID = 7'h08,
    M_MTCH = 7'h10,
    M_MCMD = 7'h20,
    M_DONE = 7'h40
  } ricg_mst_t;

  ricg_mst_t   state_ff;
  ricg_mst_t   nxt_state;
  logic [6:0]  cnt_ff;
  logic [6:0]  nxt_cnt;
  logic        pend_ff;
  logic [1:0]  op_ff;
  logic [63:0] mid_ff;
  logic [7:0]  mcmd_ff;
  logic [7:0]  sel_cmd;
  logic [63:0] id_ff;
  logic [7:0]  crc_ff;
  logic [7:0]  crc_nxt;
  logic        crc_ok_ff;
  logic        m_vld_ff;
  logic        m_bit_ff;
  logic        brst_ff;
  logic        done_ff;
  logic        busy_ff;
  logic        tx_bit;
  logic        slot_go;

  always_comb begin
    case (op_ff)
      ricg_pkg::OP_READ:  sel_cmd = ricg_pkg::CMD_READ_ID;
      ricg_pkg::OP_MATCH: sel_cmd = ricg_pkg::CMD_MATCH_ID;
      default:            sel_cmd = ricg_pkg::CMD_SKIP_ID;
    endcase
  end

  always_comb begin
    case (state_ff)
      M_CMD:   tx_bit = sel_cmd[cnt_ff[2:0]];
      M_MTCH:  tx_bit = mid_ff[cnt_ff[5:0]];
      M_MCMD:  tx_bit = mcmd_ff[cnt_ff[2:0]];
      default: tx_bit = 1'b1;
    endcase
  end

  assign slot_go = !pend_ff && !m_vld_ff &&
                   (state_ff == M_CMD || state_ff == M_RDID ||
                    state_ff == M_MTCH || state_ff == M_MCMD);
  assign crc_nxt = ricg_pkg::ricg_crc_step(crc_ff, bus.d_bit);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      M_IDLE: if (start) nxt_state = M_RST;
      M_RST:  if (bus.d_rdy && !brst_ff) nxt_state = M_CMD;
      M_CMD, M_RDID, M_MTCH, M_MCMD: if (bus.d_vld) begin
        nxt_cnt = cnt_ff + 7'h01;
        if ((state_ff == M_CMD || state_ff == M_MCMD) && cnt_ff == ricg_pkg::BYTE_LAST ||
            (state_ff == M_RDID || state_ff == M_MTCH) && cnt_ff == ricg_pkg::ID_LAST) begin
          nxt_cnt = 7'h00;
          case (state_ff)
            M_CMD:   nxt_state = (op_ff == ricg_pkg::OP_READ)  ? M_RDID :
                                 (op_ff == ricg_pkg::OP_MATCH) ? M_MTCH : M_MCMD;
            M_MCMD:  nxt_state = M_DONE;
            // memory command only after a finished selection
            default: nxt_state = M_MCMD;
          endcase
        end
      end
      M_DONE:  nxt_state = M_IDLE;
      default: nxt_state = M_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= M_IDLE;
      cnt_ff   <= 7'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_ff   <= ricg_pkg::OP_READ;
      mid_ff  <= 64'h0000_0000_0000_0000;
      mcmd_ff <= 8'h00;
    end else if (state_ff == M_IDLE && start) begin
      op_ff   <= op;
      mid_ff  <= match_id;
      mcmd_ff <= mem_cmd;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m_vld_ff <= 1'b0;
      m_bit_ff <= 1'b1;
      pend_ff  <= 1'b0;
      brst_ff  <= 1'b0;
    end else begin
      m_vld_ff <= slot_go;
      m_bit_ff <= slot_go ? tx_bit : 1'b1;
      brst_ff  <= (state_ff == M_IDLE) && start;
      if (slot_go) begin
        pend_ff <= 1'b1;
      end else if (bus.d_vld) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // identity capture and check: all 64 bits go through the register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_ff    <= ricg_pkg::CRC_INIT;
      id_ff     <= 64'h0000_0000_0000_0000;
      crc_ok_ff <= 1'b0;
    end else if (state_ff == M_IDLE && start) begin
      crc_ff    <= ricg_pkg::CRC_INIT;
      crc_ok_ff <= 1'b0;
    end else if (state_ff == M_RDID && bus.d_vld) begin
      crc_ff <= crc_nxt;
      id_ff  <= {bus.d_bit, id_ff[63:1]};
      if (cnt_ff == ricg_pkg::ID_LAST) begin
        crc_ok_ff <= (crc_nxt == 8'h00);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == M_DONE);
      busy_ff <= (nxt_state != M_IDLE);
    end
  end

  assign bus.bus_rst = brst_ff;
  assign bus.m_vld   = m_vld_ff;
  assign bus.m_bit   = m_bit_ff;
  assign busy        = busy_ff;
  assign done        = done_ff;
  assign id_read     = id_ff;
  assign crc_ok      = crc_ok_ff;
endmodule : ricg_master

// ==== testbench/ricg_sva.sv ====
`timescale 1ns/1ps
module ricg_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_rst,
  input wire logic m_vld,
  input wire logic m_bit,
  input wire logic d_vld,
  input wire logic d_bit,
  input wire logic d_rdy
);
  // saturates so a long run never wraps back into the init window
  logic [7:0] init_cnt_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_cnt_ff <= 8'h00;
    end else if (init_cnt_ff != 8'hFF) begin
      init_cnt_ff <= init_cnt_ff + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_slot_answer_next: assert property (m_vld |=> d_vld)
    else $error("slot not answered in the next cycle");
  a_answer_has_slot: assert property (d_vld |-> $past(m_vld))
    else $error("answer without a slot");
  a_zero_bit_wins: assert property ((d_vld && !$past(m_bit)) |-> !d_bit)
    else $error("line high while master drove low");
  a_idle_line_high: assert property (!d_vld |-> d_bit)
    else $error("line low outside an answer");
  a_slot_spacing: assert property (m_vld |=> !m_vld [*2])
    else $error("slots closer than three cycles");
  a_slot_after_init: assert property (m_vld |-> d_rdy)
    else $error("slot before check byte init");
  a_init_length: assert property ($rose(d_rdy) |-> init_cnt_ff >= 8'h38)
    else $error("ready before init shift finished");
  a_ready_holds: assert property (d_rdy |=> d_rdy)
    else $error("ready dropped");
  a_bus_rst_pulse: assert property (bus_rst |=> !bus_rst)
    else $error("bus reset longer than one cycle");
  a_bus_rst_no_slot: assert property (bus_rst |-> !m_vld)
    else $error("slot together with bus reset");

  c_zero_slot: cover property (m_vld && !m_bit);
  c_ready: cover property ($rose(d_rdy));
  c_bus_rst: cover property (bus_rst ##[1:50] m_vld);
endmodule : ricg_sva

// ==== testbench/rom_id_crc_gate_bench.sv ====
`timescale 1ns/1ps
module rom_id_crc_gate_bench;
  localparam logic [7:0]  FAM = 8'hC3;
  localparam logic [47:0] SER = 48'h9A4F_10E2_7B55;

  logic        clk;
  logic        rst;
  logic        start;
  logic [1:0]  op;
  logic [63:0] match_id;
  logic [7:0]  m_cmd;
  logic        busy;
  logic        done;
  logic [63:0] id_read;
  logic        crc_ok;
  logic        sel1;
  logic        sel2;
  logic [7:0]  cmd1;
  logic [7:0]  cmd2;
  logic        vld1;
  logic        vld2;
  logic        rej1;
  logic        rej2;
  logic [7:0]  chk1;
  logic [63:0] exp_id;
  logic [63:0] r_id;
  logic [63:0] r_cmp;
  logic        r_tmp;
  logic [7:0]  mems [4];
  int          fail_count;
  int          comparisons;
  int          nv1;
  int          nr1;
  int          nv2;
  int          nw;
  int          seed;

  ricg_if bus1();
  ricg_if bus2();

  ricg_device #(.FAMILY(FAM), .SERIAL(SER)) ricg_device_i (
    .bus(bus1), .clk(clk), .rst(rst), .selected(sel1), .mem_cmd(cmd1),
    .mem_cmd_vld(vld1), .mem_cmd_rej(rej1), .check_byte(chk1));
  ricg_master ricg_master_i (
    .bus(bus1), .clk(clk), .rst(rst), .start(start), .op(op), .match_id(match_id),
    .mem_cmd(m_cmd), .busy(busy), .done(done), .id_read(id_read), .crc_ok(crc_ok));
  // second device faces the bench, which may break the master's side on purpose
  ricg_device #(.FAMILY(FAM), .SERIAL(SER)) ricg_device_i2 (
    .bus(bus2), .clk(clk), .rst(rst), .selected(sel2), .mem_cmd(cmd2),
    .mem_cmd_vld(vld2), .mem_cmd_rej(rej2), .check_byte());
  ricg_sva ricg_sva_i (
    .clk(clk), .rst(rst), .bus_rst(bus1.bus_rst), .m_vld(bus1.m_vld), .m_bit(bus1.m_bit),
    .d_vld(bus1.d_vld), .d_bit(bus1.d_bit), .d_rdy(bus1.d_rdy));

  always #50 clk = ~clk;

  always @(negedge clk) begin
    nv1 += (vld1 === 1'b1);
    nr1 += (rej1 === 1'b1);
    nv2 += (vld2 === 1'b1);
  end

  function automatic logic [7:0] crc_of(input logic [63:0] v, input int n);
    logic [7:0] c;
    logic       fb;
    c = 8'h00;
    for (int k = 0; k < n; k++) begin
      fb = c[0] ^ v[k];
      c = (c >> 1) ^ (fb ? ricg_pkg::CRC_POLY_REF : 8'h00);
    end
    return c;
  endfunction : crc_of

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic give_verdict();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic run_seq(input logic [1:0] o, input logic [63:0] mid, input logic [7:0] mc);
    @(negedge clk);
    op = o;
    match_id = mid;
    m_cmd = mc;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk_val(busy, 1'b1);
    nw = 0;
    while (done !== 1'b1 && nw < 1000) begin
      @(negedge clk);
      nw++;
    end
    if (nw >= 1000) begin
      fail_count++;
      give_verdict();
    end
    chk_val(busy, 1'b0);
  endtask : run_seq

  task automatic slot(input logic b, output logic r);
    @(negedge clk);
    bus2.m_vld = 1'b1;
    bus2.m_bit = b;
    @(negedge clk);
    // the answer stands only in the cycle after the slot
    r = bus2.d_bit;
    bus2.m_vld = 1'b0;
    bus2.m_bit = ~b;
    @(negedge clk);
  endtask : slot

  task automatic pulse_rst2();
    @(negedge clk);
    bus2.bus_rst = 1'b1;
    @(negedge clk);
    bus2.bus_rst = 1'b0;
  endtask : pulse_rst2

  task automatic send_byte(input logic [7:0] v);
    logic r;
    for (int k = 0; k < 8; k++) begin
      slot(v[k], r);
    end
  endtask : send_byte

  initial begin
    #2_000_000;
    fail_count++;
    give_verdict();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    op = ricg_pkg::OP_READ;
    match_id = 64'h0000_0000_0000_0000;
    m_cmd = 8'h00;
    bus2.bus_rst = 1'b0;
    bus2.m_vld = 1'b0;
    bus2.m_bit = 1'b1;
    fail_count = 0;
    comparisons = 0;
    nv1 = 0;
    nr1 = 0;
    nv2 = 0;
    mems = '{ricg_pkg::MEM_WR_SP, ricg_pkg::MEM_RD_SP, ricg_pkg::MEM_CP_SP, ricg_pkg::MEM_RD_MEM};
    seed = $urandom(32'h9b8e515f);
    exp_id = {crc_of({8'h00, SER, FAM}, 56), SER, FAM};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      op = (i == 0) ? ricg_pkg::OP_READ : 2'($urandom % 4);
      run_seq(op, exp_id, mems[i]);
      chk_val(nv1, i + 1);
      chk_val(cmd1, mems[i]);
      chk_val(sel1, 1'b1);
      if (op == ricg_pkg::OP_READ) begin
        chk_val(id_read, exp_id);
        chk_val(crc_ok, 1'b1);
      end
    end
    chk_val(chk1, exp_id[63:56]);
    run_seq(ricg_pkg::OP_MATCH, exp_id ^ (64'h1 << ($urandom % 64)), mems[1]);
    chk_val(nv1, 4);
    chk_val(sel1, 1'b0);
    run_seq(ricg_pkg::OP_SKIP, exp_id, 8'h3C);
    chk_val(nr1, 1);
    chk_val(nv1, 4);
    run_seq(ricg_pkg::OP_READ, exp_id, mems[$urandom % 4]);
    chk_val(crc_ok, 1'b1);
    while (bus2.d_rdy !== 1'b1) @(negedge clk);
    pulse_rst2();
    send_byte(ricg_pkg::MEM_WR_SP);
    send_byte(ricg_pkg::CMD_SKIP_ID);
    send_byte(ricg_pkg::MEM_RD_SP);
    chk_val(nv2, 0);
    chk_val(sel2, 1'b0);
    pulse_rst2();
    send_byte(ricg_pkg::CMD_READ_ID);
    for (int k = 0; k < 64; k++) begin
      slot(1'b1, r_id[k]);
    end
    chk_val(r_id, exp_id);
    chk_val(crc_of(r_id, 64), 8'h00);
    send_byte(ricg_pkg::MEM_RD_MEM);
    chk_val(nv2, 1);
    chk_val(cmd2, ricg_pkg::MEM_RD_MEM);
    // search: read bit, read complement, then write the bit back
    pulse_rst2();
    send_byte(ricg_pkg::CMD_SRCH_ID);
    for (int k = 0; k < 64; k++) begin
      slot(1'b1, r_id[k]);
      slot(1'b1, r_cmp[k]);
      slot(r_id[k], r_tmp);
    end
    chk_val(r_id, exp_id);
    chk_val(r_cmp, ~exp_id);
    send_byte(ricg_pkg::MEM_RD_SP);
    chk_val(nv2, 2);
    chk_val(cmd2, ricg_pkg::MEM_RD_SP);
    pulse_rst2();
    repeat (2) @(negedge clk);
    chk_val(sel2, 1'b0);
    give_verdict();
  end
endmodule : rom_id_crc_gate_bench
